// file: verilog/lnb_pkg.sv
// Shared constants and types of the antenna supply pin control block.
// Assumes a 20 MHz reference clock and a 32-bit Avalon-MM register bus.
package lnb_pkg;

    // ----------------
    // Timing
    // ----------------
    localparam int CLK_FREQ_HZ   = 20_000_000;
    localparam int TONE_FREQ_HZ  = 22_000;
    // Half period of the internal tone, rounded down to whole cycles
    localparam int TONE_HALF_CYC = CLK_FREQ_HZ / (2 * TONE_FREQ_HZ);
    localparam int TONE_CNT_W    = 9;

    // ----------------
    // Register map (byte addresses)
    // ----------------
    localparam logic [4:0] OFF_CTRL_A   = 5'h00;
    localparam logic [4:0] OFF_CTRL_B   = 5'h04;
    localparam logic [4:0] OFF_STATUS   = 5'h08;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h0C;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

    // Interrupt status bit positions
    localparam int IRQ_OVERTEMP = 0;
    localparam int IRQ_SUPPLY_UNDERVOLTAGE_LOCKOUT     = 1;
    localparam int IRQ_TDET_A   = 2;
    localparam int IRQ_TDET_B   = 3;
    localparam int IRQ_W        = 4;

    // Status register field positions
    localparam int ST_CHAN_W    = 4;
    localparam int ST_OVERTEMP  = 8;
    localparam int ST_SUPPLY_UNDERVOLTAGE_LOCKOUT      = 9;
    localparam int ST_ADDR_LSB  = 10;

    // Per-channel control word, high bit first in the register
    typedef struct packed {
        logic chanEn;
        logic modulationSelectBit;
        logic toneEnableBit;
        logic thresholdSelectBit;
        logic pinSelectEnableBit;
        logic highRangeLevelBit;
        logic lowRangeLevelBit;
    } lnb_ctrl_t;

    localparam lnb_ctrl_t CTRL_RESET = 7'h00;
    localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;

    // Selection presented to one antenna supply output
    typedef struct packed {
        logic rangeHigh;    // 1: 18V/19V range, 0: 13V/14V range
        logic levelUp;      // 1: upper level of the range
        logic tone;         // Tone waveform superimposed on the output
    } lnb_supply_t;

    // Upper bits of the serial-bus device address (arbitrary value)
    localparam logic [4:0] SLAVE_ADDR_BASE = 5'h00;

endpackage : lnb_pkg

// file: verilog/lnb_sync3.sv
// Three-stage synchroniser for asynchronous pin inputs.
// Assumes pins change slowly against the reference clock.
`timescale 1ns/1ps
module lnb_sync3 #(
    parameter int W = 1
) (
    input  wire logic         refClk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] syncOut
);
    import lnb_pkg::*;

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_d;
    logic [W-1:0] out_q;

    // ------------------------------------------------------------------
    // Accept a change once the second and third stages agree
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < W; i++) begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
        end
    end

    // Stage registers; the first stage feeds only the second
    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= pinIn;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign syncOut = out_q;
endmodule : lnb_sync3

// file: verilog/lnb_tone_chan.sv
// Tone source of one channel: internal oscillator, envelope gating and
// pass-through of an externally modulated tone.
// Assumes the modulation input is already synchronised.
`timescale 1ns/1ps
module lnb_tone_chan (
    input  wire logic refClk,
    input  wire logic rstn,
    input  wire logic chanEn,
    input  wire logic toneEnableBit,
    input  wire logic modulationSelectBit,
    input  wire logic toneModIn,
    output logic      toneOut
);
    import lnb_pkg::*;

    logic [TONE_CNT_W-1:0] cnt_q;
    logic [TONE_CNT_W-1:0] cnt_d;
    logic                  osc_q;
    logic                  osc_d;
    logic                  tone_q;
    logic                  tone_d;

    // ------------------------------------------------------------------
    // Free-running 22 kHz oscillator and output selection
    // ------------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q + 1'b1;
        osc_d = osc_q;
        if (cnt_q == TONE_CNT_W'(TONE_HALF_CYC - 1)) begin
            cnt_d = '0;
            osc_d = ~osc_q;
        end
        if (!chanEn) begin
            tone_d = 1'b0;
        end else if (toneEnableBit) begin
            tone_d = osc_q;                 // Continuous tone
        end else if (modulationSelectBit) begin
            tone_d = toneModIn;             // External tone
        end else begin
            tone_d = osc_q & toneModIn;     // Envelope burst
        end
    end

    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= '0;
            osc_q  <= 1'b0;
            tone_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            osc_q  <= osc_d;
            tone_q <= tone_d;
        end
    end

    assign toneOut = tone_q;
endmodule : lnb_tone_chan

// file: verilog/lnb_pin_ctrl.sv
// Pin control logic of a dual antenna supply regulator: range selection,
// tone decoder threshold, tone sources, open-drain flags, gate hold-off,
// slave address selection and an Avalon-MM register slave.
// Assumes one 20 MHz clock; all pins other than pwm inputs are async.
//
// Behaviour
// - Tx pin low gives receive threshold, high gives transmit threshold.
// - Threshold select bit drives the tx pin high, forcing transmit mode.
// - Active range pin low selects 13V/14V range, level by low level bit.
// - Active range pin high selects 18V/19V range, level by high bit.
// - Pin select enable high ignores the pin; level bits alone choose.
// - Fault output pulled low on over-temperature.
// - Fault output released high while no fault is present.
// - Fault output is open-drain, only pulls low.
// - Both boost gate drives forced low during undervoltage lockout.
// - Two address pins choose one of four device addresses.
// - External tone mode passes modulation input onto the output.
// - Envelope mode gates internal tone with the modulation input.
// - Tone detect outputs are open-drain per channel.
// - Tone detect output pulled low while tone is detected.
// - Tone enable bit gives continuous tone regardless of the input.
// - Modulation select high means external tone, low means envelope.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module lnb_pin_ctrl (
    input  wire logic                refClk,
    input  wire logic                rstn,
    // Avalon-MM slave
    input  wire logic [4:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    output logic                     irq,
    // Range select pins
    input  wire logic                highRangeSelectPinA,
    input  wire logic                highRangeSelectPinB,
    // Tone transmit pins, two-way
    input  wire logic                toneTransmitPinAIn,
    output logic                     toneTransmitPinAOut,
    output logic                     toneTransmitPinAOe,
    input  wire logic                toneTransmitPinBIn,
    output logic                     toneTransmitPinBOut,
    output logic                     toneTransmitPinBOe,
    output logic                     thresholdHighA,
    output logic                     thresholdHighB,
    // Tone modulation and detection
    input  wire logic                toneModulationInputA,
    input  wire logic                toneModulationInputB,
    input  wire logic                toneDetectInputA,
    input  wire logic                toneDetectInputB,
    output logic                     toneDetectOutNAOut,
    output logic                     toneDetectOutNAOe,
    output logic                     toneDetectOutNBOut,
    output logic                     toneDetectOutNBOe,
    // Fault, lockout and gate drive
    input  wire logic                overTemp,
    input  wire logic                supplyUndervoltageLockout,
    output logic                     faultOutNOut,
    output logic                     faultOutNOe,
    input  wire logic                pwmA,
    input  wire logic                pwmB,
    output logic                     boostGateDriveA,
    output logic                     boostGateDriveB,
    // Address selection
    input  wire logic                slaveAddressSelect0,
    input  wire logic                slaveAddressSelect1,
    output logic      [6:0]          busAddress,
    // Supply output selection
    output lnb_pkg::lnb_supply_t     antennaSupplyOutA,
    output lnb_pkg::lnb_supply_t     antennaSupplyOutB
);
    import lnb_pkg::*;

    // ----------------
    // Pin synchronisation
    // ----------------
    localparam int SYN_W = 12;

    logic [SYN_W-1:0] pinRaw;
    logic [SYN_W-1:0] pinSync;
    logic [1:0]       selPinS;
    logic [1:0]       txPinS;
    logic [1:0]       modInS;
    logic [1:0]       tdInS;
    logic             uvloS;
    logic             otS;
    logic [1:0]       addrS;

    // Async pins bundled for one synchroniser
    assign pinRaw = {slaveAddressSelect1, slaveAddressSelect0,
                     overTemp, supplyUndervoltageLockout,
                     toneDetectInputB, toneDetectInputA,
                     toneModulationInputB, toneModulationInputA,
                     toneTransmitPinBIn, toneTransmitPinAIn,
                     highRangeSelectPinB, highRangeSelectPinA};

    lnb_sync3 #(
        .W       (SYN_W)
    ) uSync (
        .refClk  (refClk),
        .rstn    (rstn),
        .pinIn   (pinRaw),
        .syncOut (pinSync)
    );

    assign selPinS = pinSync[1:0];
    assign txPinS  = pinSync[3:2];
    assign modInS  = pinSync[5:4];
    assign tdInS   = pinSync[7:6];
    assign uvloS   = pinSync[8];
    assign otS     = pinSync[9];
    assign addrS   = pinSync[11:10];

    // ----------------
    // Register bus and interrupt state
    // ----------------
    lnb_ctrl_t        ctrl_q [2];
    lnb_ctrl_t        ctrl_d [2];
    logic [IRQ_W-1:0] istat_q;
    logic [IRQ_W-1:0] istat_d;
    logic [IRQ_W-1:0] imask_q;
    logic [IRQ_W-1:0] imask_d;
    logic [IRQ_W-1:0] event_d;
    logic [IRQ_W-1:0] evLvl_q;
    logic [IRQ_W-1:0] evLvl;
    logic             ack_q;
    logic             ack_d;
    logic [31:0]      rdata_q;
    logic [31:0]      rdata_d;
    logic [31:0]      status;
    logic             wrTake;
    logic             rdTake;
    logic [1:0]       rangeHigh_q;
    logic [1:0]       levelUp_q;
    logic [1:0]       rangeHigh_d;
    logic [1:0]       levelUp_d;
    logic [1:0]       txMode;
    logic [1:0]       toneOut;

    // Request is answered one edge after it first appears
    assign waitrequest = (read | write) & ~ack_q;
    assign wrTake      = write & ack_q;
    assign rdTake      = read & ack_q;
    assign readdata    = rdata_q;

    // Level sources of the interrupt events
    assign evLvl = {tdInS[1], tdInS[0], uvloS, otS};

    // Readable block state
    always_comb begin
        status = '0;
        for (int c = 0; c < 2; c++) begin
            status[c*ST_CHAN_W +: ST_CHAN_W] =
                {tdInS[c], txMode[c], levelUp_q[c], rangeHigh_q[c]};
        end
        status[ST_OVERTEMP] = otS;          // Fault cause for host
        status[ST_SUPPLY_UNDERVOLTAGE_LOCKOUT]     = uvloS;
        status[ST_ADDR_LSB +: 2] = addrS;
    end

    // Next values of control, mask, status and read data
    always_comb begin
        ctrl_d  = ctrl_q;
        imask_d = imask_q;
        rdata_d = rdata_q;
        ack_d   = (read | write) & ~ack_q;
        event_d = evLvl & ~evLvl_q;
        istat_d = istat_q;
        if (wrTake) begin
            case (address)
                OFF_CTRL_A:   ctrl_d[0] = lnb_ctrl_t'(writedata[6:0]);
                OFF_CTRL_B:   ctrl_d[1] = lnb_ctrl_t'(writedata[6:0]);
                OFF_IRQ_MASK: imask_d = writedata[IRQ_W-1:0];
                default:      ;
            endcase
        end
        if (read & ~ack_q) begin
            case (address)
                OFF_CTRL_A:   rdata_d = {25'h0, ctrl_q[0]};
                OFF_CTRL_B:   rdata_d = {25'h0, ctrl_q[1]};
                OFF_STATUS:   rdata_d = status;
                OFF_IRQ_STAT: rdata_d = {28'h0, istat_q};
                OFF_IRQ_MASK: rdata_d = {28'h0, imask_q};
                default:      rdata_d = 32'h0;
            endcase
        end
        // A read clears only the bits it reported; new events win
        if (rdTake && address == OFF_IRQ_STAT) begin
            istat_d = istat_q & ~rdata_q[IRQ_W-1:0];
        end
        istat_d = istat_d | event_d;
    end

    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q[0] <= CTRL_RESET;
            ctrl_q[1] <= CTRL_RESET;
            imask_q   <= MASK_RESET;
            istat_q   <= '0;
            evLvl_q   <= '0;
            ack_q     <= 1'b0;
            rdata_q   <= 32'h0;
        end else begin
            ctrl_q    <= ctrl_d;
            imask_q   <= imask_d;
            istat_q   <= istat_d;
            evLvl_q   <= evLvl;
            ack_q     <= ack_d;
            rdata_q   <= rdata_d;
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(istat_q & imask_q);

    // ----------------
    // Per-channel range, threshold, tone and detect logic
    // ----------------
    logic [1:0] txPinOut;
    logic [1:0] txPinOe;
    logic [1:0] tdOe;

    for (genvar c = 0; c < 2; c++) begin : gChan
        // Range pin acts only while pin select enable is low
        always_comb begin
            if (!ctrl_q[c].pinSelectEnableBit) begin
                rangeHigh_d[c] = selPinS[c];
                levelUp_d[c]   = selPinS[c]
                               ? ctrl_q[c].highRangeLevelBit
                               : ctrl_q[c].lowRangeLevelBit;
            end else begin
                rangeHigh_d[c] = ctrl_q[c].highRangeLevelBit;
                levelUp_d[c]   = ctrl_q[c].lowRangeLevelBit;
            end
        end

        // Threshold bit drives the tx pin high through the driver
        assign txPinOut[c] = ctrl_q[c].thresholdSelectBit;
        assign txPinOe[c]  = ctrl_q[c].thresholdSelectBit;
        // Transmit threshold when pin or bit is high
        assign txMode[c] = txPinS[c] | ctrl_q[c].thresholdSelectBit;

        // Open-drain detect flag pulls low on detected tone
        assign tdOe[c] = tdInS[c];

        lnb_tone_chan uTone (
            .refClk              (refClk),
            .rstn                (rstn),
            .chanEn              (ctrl_q[c].chanEn),
            .toneEnableBit       (ctrl_q[c].toneEnableBit),
            .modulationSelectBit (ctrl_q[c].modulationSelectBit),
            .toneModIn           (modInS[c]),
            .toneOut             (toneOut[c])
        );
    end

    // Registered range and level selection
    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            rangeHigh_q <= '0;
            levelUp_q   <= '0;
        end else begin
            rangeHigh_q <= rangeHigh_d;
            levelUp_q   <= levelUp_d;
        end
    end

    assign antennaSupplyOutA = '{rangeHigh_q[0], levelUp_q[0], toneOut[0]};
    assign antennaSupplyOutB = '{rangeHigh_q[1], levelUp_q[1], toneOut[1]};

    assign toneTransmitPinAOut = txPinOut[0];
    assign toneTransmitPinAOe  = txPinOe[0];
    assign toneTransmitPinBOut = txPinOut[1];
    assign toneTransmitPinBOe  = txPinOe[1];
    assign thresholdHighA      = txMode[0];
    assign thresholdHighB      = txMode[1];

    assign toneDetectOutNAOut  = 1'b0;      // Only ever pulls low
    assign toneDetectOutNAOe   = tdOe[0];
    assign toneDetectOutNBOut  = 1'b0;
    assign toneDetectOutNBOe   = tdOe[1];

    // ----------------
    // Fault flag, gate hold-off and address
    // ----------------
    assign faultOutNOut = 1'b0;             // Never drives high
    assign faultOutNOe  = otS;              // Low on over-temp

    logic [1:0] gate_q;
    logic [1:0] gate_d;

    // Gates follow pwm only on enabled channels outside lockout
    always_comb begin
        gate_d[0] = pwmA & ctrl_q[0].chanEn & ~uvloS;
        gate_d[1] = pwmB & ctrl_q[1].chanEn & ~uvloS;
    end

    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            gate_q <= '0;
        end else begin
            gate_q <= gate_d;
        end
    end

    // Raw lockout also forces low without synchroniser delay
    assign boostGateDriveA = gate_q[0] & ~supplyUndervoltageLockout;
    assign boostGateDriveB = gate_q[1] & ~supplyUndervoltageLockout;

    // Device address from base and the two select pins
    assign busAddress = {SLAVE_ADDR_BASE, addrS};

endmodule : lnb_pin_ctrl

// file: bench/lnb_pin_ctrl_assertions.sv
// Port checker of the antenna supply pin control block.
// Assumes one clock domain; bound to the top from the bench.
`timescale 1ns/1ps
module lnb_pin_ctrl_assertions (
    input wire logic       refClk,
    input wire logic       rstn,
    input wire logic       read,
    input wire logic       write,
    input wire logic       waitrequest,
    input wire logic       toneTransmitPinAIn,
    input wire logic       toneTransmitPinAOut,
    input wire logic       toneTransmitPinAOe,
    input wire logic       thresholdHighA,
    input wire logic       toneDetectInputA,
    input wire logic       toneDetectOutNAOut,
    input wire logic       toneDetectOutNAOe,
    input wire logic       overTemp,
    input wire logic       supplyUndervoltageLockout,
    input wire logic       faultOutNOut,
    input wire logic       faultOutNOe,
    input wire logic       boostGateDriveA,
    input wire logic       boostGateDriveB,
    input wire logic       slaveAddressSelect0,
    input wire logic       slaveAddressSelect1,
    input wire logic [6:0] busAddress
);
    import lnb_pkg::*;
    default clocking cb @(posedge refClk); endclocking
    default disable iff (!rstn);
    // Pin levels held long enough to pass the synchroniser
    sequence otHeld; overTemp[*6]; endsequence
    sequence otGone; !overTemp[*6]; endsequence
    sequence selHeld;
        $stable({slaveAddressSelect1, slaveAddressSelect0})[*8];
    endsequence
    fault_od_a: assert property (faultOutNOut == 1'b0)
        else $error("fault pin driven high");
    fault_set_a: assert property (otHeld |-> faultOutNOe)
        else $error("fault not pulled low");
    fault_clr_a: assert property (otGone |-> !faultOutNOe)
        else $error("fault pulled low without cause");
    gate_hold_a: assert property (supplyUndervoltageLockout
        |-> !(boostGateDriveA || boostGateDriveB))
        else $error("gate drive during lockout");
    tdet_low_a: assert property (toneDetectInputA[*6]
        |-> toneDetectOutNAOe && !toneDetectOutNAOut)
        else $error("tone detect not pulled low");
    tx_drive_a: assert property (toneTransmitPinAOe
        |-> toneTransmitPinAOut)
        else $error("tx pin driven low");
    thr_tx_a: assert property (toneTransmitPinAIn[*6]
        |-> thresholdHighA)
        else $error("receive threshold in tx mode");
    thr_rx_a: assert property ((!toneTransmitPinAIn
        && !toneTransmitPinAOe)[*6] |-> !thresholdHighA)
        else $error("transmit threshold in rx mode");
    addr_pick_a: assert property (selHeld |-> busAddress ==
        {SLAVE_ADDR_BASE, slaveAddressSelect1, slaveAddressSelect0})
        else $error("wrong bus address");
    wait_one_a: assert property ((read || write) && waitrequest
        |=> !waitrequest)
        else $error("bus answer late");
endmodule : lnb_pin_ctrl_assertions

// file: bench/lnb_pin_env.sv
// Pin side of one channel: tx line with pull-down and remote driver,
// and an open-drain line with pull-up.
`timescale 1ns/1ps
module lnb_pin_env (
    input  wire logic txOut,
    input  wire logic txOe,
    input  wire logic extDrv,
    input  wire logic extLvl,
    output logic      txWire,
    input  wire logic odOut,
    input  wire logic odOe,
    output logic      odWire
);
    // Pull-down wins only when nobody drives the tx line
    assign txWire = txOe ? txOut : (extDrv ? extLvl : 1'b0);
    // Pull-up holds a released open-drain line high
    assign odWire = odOe ? odOut : 1'b1;
endmodule : lnb_pin_env

// file: bench/lnb_pin_ctrl_tb.sv
// Bench of the pin control block: Avalon tasks and pin stimulus.
// Assumes the pin model file and the checker compile first.
`timescale 1ns/1ps
module lnb_pin_ctrl_tb;
    import lnb_pkg::*;
    logic        refClk, rstn, read, write, waitrequest, irq;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, q;
    logic        highRangeSelectPinA, highRangeSelectPinB;
    logic        toneTransmitPinAIn, toneTransmitPinAOut, toneTransmitPinAOe;
    logic        toneTransmitPinBIn, toneTransmitPinBOut, toneTransmitPinBOe;
    logic        thresholdHighA, thresholdHighB, pwmA, pwmB;
    logic        toneModulationInputA, toneModulationInputB;
    logic        toneDetectInputA, toneDetectInputB;
    logic        toneDetectOutNAOut, toneDetectOutNAOe;
    logic        toneDetectOutNBOut, toneDetectOutNBOe;
    logic        overTemp, supplyUndervoltageLockout;
    logic        faultOutNOut, faultOutNOe;
    logic        boostGateDriveA, boostGateDriveB;
    logic        slaveAddressSelect0, slaveAddressSelect1;
    logic [6:0]  busAddress;
    lnb_supply_t antennaSupplyOutA, antennaSupplyOutB;
    logic        extDrv, extLvl, tdWireA, tdWireB, fltWire, rh, lu;
    int          n_mismatch, checked, cyc, t;

    lnb_pin_ctrl u_dut (.*);
    lnb_pin_env u_envA (.txOut(toneTransmitPinAOut), .extDrv, .extLvl,
        .txOe(toneTransmitPinAOe), .txWire(toneTransmitPinAIn),
        .odOut(toneDetectOutNAOut), .odOe(toneDetectOutNAOe),
        .odWire(tdWireA));
    lnb_pin_env u_envB (.txOut(toneTransmitPinBOut), .extDrv, .extLvl,
        .txOe(toneTransmitPinBOe), .txWire(toneTransmitPinBIn),
        .odOut(toneDetectOutNBOut), .odOe(toneDetectOutNBOe),
        .odWire(tdWireB));
    // Fault line pulled up outside the device
    assign fltWire = faultOutNOe ? faultOutNOut : 1'b1;

    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input logic [31:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %0h", $time, m, got);
        end
    endtask : chk

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input int r, input logic [4:0] a,
                       input logic [31:0] d);
        address <= a;
        read <= r != 0;
        write <= r == 0;
        writedata <= d;
        do @(posedge refClk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge refClk);
    endtask : bus

    task automatic wt(input int c);
        repeat (c) @(posedge refClk);
    endtask : wt

    // Counts changes of the channel A tone over c cycles
    task automatic tog(input int c);
        logic p;
        t = 0;
        p = antennaSupplyOutA.tone;
        repeat (c) begin
            @(negedge refClk);
            if (antennaSupplyOutA.tone !== p) t++;
            p = antennaSupplyOutA.tone;
        end
        @(posedge refClk);
    endtask : tog

    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    initial begin
        refClk = 1'b0;
        forever #25 refClk = ~refClk;
    end
    // Cycle ceiling against a hung run
    always @(posedge refClk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end

    // ----------------
    // Tests
    // ----------------
    initial begin
        {rstn, read, write, address, writedata, extDrv, extLvl} = '0;
        {highRangeSelectPinA, highRangeSelectPinB, pwmA, pwmB} = '0;
        {toneModulationInputA, toneModulationInputB, overTemp} = '0;
        {toneDetectInputA, toneDetectInputB} = '0;
        {supplyUndervoltageLockout, slaveAddressSelect0} = '0;
        slaveAddressSelect1 = 1'b0;
        wt(2);
        rstn <= 1'b1;
        bus(0, 5'h14, 32'hFF);
        for (int i = 0; i < 6; i++) begin
            bus(1, 5'(4 * i), 0);
            chk(q, 0, "reset or unmapped");
        end
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            bus(0, OFF_CTRL_A, i & 7);
            bus(0, OFF_CTRL_B, i & 7);
            highRangeSelectPinA <= i[3];
            highRangeSelectPinB <= i[3];
            wt(8);
            rh = i[2] ? i[1] : i[3];
            lu = (i[3] && !i[2]) ? i[1] : i[0];
            chk({antennaSupplyOutA[2:1], antennaSupplyOutB[2:1]},
                {rh, lu, rh, lu}, "range");
            bus(1, OFF_STATUS, 0);
            chk({q[5:4], q[1:0]}, {lu, rh, lu, rh}, "status");
        end
        bus(1, OFF_CTRL_B, 0);
        chk(q, 7, "ctrl readback");
        $display("range test done");
        extDrv <= 1'b1;
        extLvl <= 1'b1;
        wt(8);
        chk({thresholdHighA, thresholdHighB}, 2'b11, "tx thr");
        extDrv <= 1'b0;
        wt(8);
        chk({thresholdHighA, thresholdHighB}, 2'b00, "rx thr");
        bus(0, OFF_CTRL_A, 32'h08);
        bus(0, OFF_CTRL_B, 32'h08);
        wt(8);
        chk({toneTransmitPinAOe, toneTransmitPinAIn, thresholdHighA,
             toneTransmitPinBOe, toneTransmitPinBIn, thresholdHighB},
            6'h3F, "tx drive");
        $display("threshold test done");
        bus(0, OFF_CTRL_A, 32'h50);
        tog(1000);
        chk(t >= 2, 1, "continuous tone");
        bus(0, OFF_CTRL_A, 32'h40);
        wt(8);
        tog(1000);
        chk(t, 0, "envelope off");
        toneModulationInputA <= 1'b1;
        tog(1000);
        chk(t >= 2, 1, "envelope on");
        bus(0, OFF_CTRL_A, 32'h60);
        wt(8);
        chk(antennaSupplyOutA.tone, 1, "ext tone high");
        toneModulationInputA <= 1'b0;
        wt(8);
        chk(antennaSupplyOutA.tone, 0, "ext tone low");
        $display("tone test done");
        bus(0, OFF_CTRL_B, 32'h40);
        bus(0, OFF_IRQ_MASK, 32'h1);
        {pwmA, pwmB, overTemp} <= 3'b111;
        wt(8);
        chk({fltWire, irq, boostGateDriveA, boostGateDriveB}, 4'h7,
            "fault on");
        bus(1, OFF_STATUS, 0);
        chk(q[8], 1, "fault cause");
        overTemp <= 1'b0;
        wt(8);
        chk(fltWire, 1, "fault off");
        bus(1, OFF_IRQ_STAT, 0);
        chk(q, 32'h1, "fault event");
        supplyUndervoltageLockout <= 1'b1;
        wt(8);
        chk({irq, boostGateDriveA, boostGateDriveB}, 0, "lockout");
        bus(0, OFF_IRQ_MASK, 32'hE);
        wt(1);
        chk(irq, 1, "unmasked");
        supplyUndervoltageLockout <= 1'b0;
        bus(1, OFF_IRQ_STAT, 0);
        chk(q, 32'h2, "lockout event");
        wt(8);
        chk({irq, boostGateDriveA, boostGateDriveB}, 3, "gates back");
        {toneDetectInputA, toneDetectInputB} <= 2'b11;
        wt(8);
        chk({tdWireA, tdWireB, irq}, 1, "tone seen");
        {toneDetectInputA, toneDetectInputB} <= 2'b00;
        wt(8);
        chk({tdWireA, tdWireB}, 3, "tone gone");
        bus(1, OFF_IRQ_STAT, 0);
        chk(q, 32'hC, "tone events");
        $display("flag test done");
        for (int i = 0; i < 4; i++) begin
            {slaveAddressSelect1, slaveAddressSelect0} <= i[1:0];
            wt(8);
            chk(busAddress, {SLAVE_ADDR_BASE, i[1:0]}, "addr");
            bus(1, OFF_STATUS, 0);
            chk(q[11:10], i, "addr field");
        end
        $display("address test done");
        results();
    end
endmodule : lnb_pin_ctrl_tb

bind lnb_pin_ctrl lnb_pin_ctrl_assertions u_chk (.*);
